// ---- rtl/dst_pkg.sv ----
/*
 * Constants shared by both ends of the self-test and test-bus link:
 * command codes, register offsets, field positions and the signature.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dst_pkg;

   // ****************************************************************
   // Link commands and register indexes
   // ****************************************************************
   typedef enum logic [1:0] {
      DST_OP_NONE = 2'h0,
      DST_OP_WREG = 2'h1,
      DST_OP_CMD  = 2'h2,
      DST_OP_RDFF = 2'h3
   } dst_op_t;

   localparam logic [3:0] CMD_IDLE = 4'h0;
   localparam logic [3:0] CMD_BUFFER_STORE = 4'h1;
   localparam logic [3:0] CMD_CRC_CALCULATE = 4'h3;
   localparam logic [3:0] CMD_SOFT_RESET = 4'hF;

   localparam logic [5:0] REG_FIFO_DATA = 6'h09;
   localparam logic [5:0] REG_TEST_SELECT_TWO = 6'h32;
   localparam logic [5:0] REG_SELF_TEST_CONTROL = 6'h36;

   localparam logic [7:0] SELF_TEST_ENABLE = 8'h09;
   localparam logic [7:0] FILL_BYTE = 8'h00;
   localparam int BUFFER_CLEAR_BYTES = 25;
   localparam int SIGNATURE_BYTES = 64;
   localparam int FIFO_DEPTH = 64;
   localparam logic [4:0] RESET_CYCLES = 5'h10;

   // Test-bus select field and codes.
   localparam int TBS_MSB = 4;
   localparam logic [4:0] TBS_RECEIVER = 5'h07;
   localparam logic [4:0] TBS_CLOCK = 5'h0D;
   localparam int PIN_D6 = 5;
   localparam int PIN_D5 = 4;
   localparam int PIN_D4 = 3;
   localparam int PIN_D3 = 2;
   localparam int PIN_D2 = 1;
   localparam int PIN_D1 = 0;

   // ****************************************************************
   // Host APB registers
   // ****************************************************************
   localparam logic [7:0] APB_CTRL = 8'h00;
   localparam logic [7:0] APB_STATUS = 8'h04;
   localparam logic [7:0] APB_TBSEL = 8'h08;
   localparam logic [7:0] APB_RDATA = 8'h0C;
   localparam int CTRL_START = 0;
   localparam int CTRL_TBWR = 1;
   localparam int CTRL_POP = 2;

   // Fixed signature, byte 0 first.
   localparam logic [511:0] SIGNATURE = {
      64'h00EB66BA57BF2395, 64'hD0E30D3D27895CDE,
      64'h9D3BA700215B8982, 64'h513AEB020CA50049,
      64'h7C844DB3CCD21B81, 64'h5D4876D5716121A9,
      64'h86968338CF9D5B6D, 64'hDC15BA3E7D953B2F};

endpackage

// ---- rtl/dst_link_if.sv ----
/*
 * Byte-command link between host controller and self-test device.
 * Assumes both ends run on the same sys_clk.
 */
`timescale 1ns/1ns
interface dst_link_if;
   logic reqValid;
   dst_pkg::dst_op_t reqOp;
   logic [5:0] reqAddr;
   logic [7:0] reqData;
   logic devBusy;
   logic rspValid;
   logic [7:0] rspData;
   logic [5:0] testPins;

   modport host (output reqValid, reqOp, reqAddr, reqData,
      input devBusy, rspValid, rspData, testPins);
   modport device (input reqValid, reqOp, reqAddr, reqData,
      output devBusy, rspValid, rspData, testPins);
endinterface

// ---- rtl/dst_device.sv ----
/*
 * Self-test device end: FIFO, command decoder, signature engine and
 * test-bus pin multiplexer.
 * Assumes a host that keeps the self-test procedure order.
 */
`timescale 1ns/1ns
// Overview of operation
// - Host soft-resets and waits for completion.
// - Host clears buffer: 25 zeros, store.
// - Host writes 09h to self-test control.
// - Host puts one zero byte into FIFO.
// - CRC command with self-test enabled triggers test.
// - Completed test leaves 64 signature bytes.
// - Five-bit select routes test sets to pins.
// - Select 07h shows receiver signals on pins.
// - Host frames each transfer separately.
// - Select 0Dh shows oscillator signals on pins.
module dst_device (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Link to host.
   dst_link_if.device link,
   // Internal receiver and oscillator signals.
   input wire logic rxData,
   input wire logic rxCollision,
   input wire logic rxValid,
   input wire logic rxStop,
   input wire logic receiver_reset_flag,
   input wire logic clkStable,
   input wire logic oscClk,
   // Normal pin function.
   input wire logic [5:0] normalPins,
   // Status.
   output logic selfTestDone
);

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] fifoMem [dst_pkg::FIFO_DEPTH];
   logic [6:0] fifoCnt_r;
   logic [5:0] rdPtr_r;
   logic [5:0] wrPtr_r;
   logic [7:0] selfTestCtrl_r;
   logic [7:0] testSelTwo_r;
   logic [4:0] rstCnt_r;
   logic running_r;
   logic [6:0] sigIdx_r;
   logic rspValid_r;
   logic [7:0] rspData_r;
   logic done_r;
   logic [5:0] pins_r;
   logic [2:0] oscDiv_r;
   logic oscClkPrev_r;
   logic [1:0] syncA_r;
   logic [1:0] syncB_r;
   logic [6:0] syncC_r;
   logic [6:0] syncD_r;

   // ****************************************************************
   // Request decode
   // ****************************************************************
   wire isCmd = link.reqValid && link.reqOp == dst_pkg::DST_OP_CMD;
   wire isWreg = link.reqValid && link.reqOp == dst_pkg::DST_OP_WREG;
   wire isRead = link.reqValid && link.reqOp == dst_pkg::DST_OP_RDFF;
   wire cmdReset = isCmd && link.reqData[3:0] == dst_pkg::CMD_SOFT_RESET;
   wire cmdStore = isCmd && link.reqData[3:0] == dst_pkg::CMD_BUFFER_STORE;
   wire testEn = selfTestCtrl_r == dst_pkg::SELF_TEST_ENABLE;
   wire cmdCrc = isCmd && link.reqData[3:0] == dst_pkg::CMD_CRC_CALCULATE;
   wire startTest = cmdCrc && testEn;
   wire fifoWr = isWreg && link.reqAddr == dst_pkg::REG_FIFO_DATA
      && fifoCnt_r != 7'(dst_pkg::FIFO_DEPTH);
   wire fifoRd = isRead && fifoCnt_r != 7'h00;
   wire busy = rstCnt_r != 5'h00 || running_r;
   wire [8:0] sigBit = 9'(511 - 8 * sigIdx_r);
   wire [7:0] sigByte = dst_pkg::SIGNATURE[sigBit -: 8];

   // ****************************************************************
   // Soft reset, registers and self-test engine
   // ****************************************************************
   // Soft reset clears registers and holds busy for a fixed time.
   always_ff @(posedge sys_clk) begin
      if (srst || (cmdReset && !busy)) begin
         rstCnt_r <= srst ? 5'h00 : dst_pkg::RESET_CYCLES;
         selfTestCtrl_r <= 8'h00;
         testSelTwo_r <= 8'h00;
         running_r <= 1'b0;
         sigIdx_r <= 7'h00;
         done_r <= 1'b0;
      end else begin
         if (rstCnt_r != 5'h00) begin
            rstCnt_r <= rstCnt_r - 5'h01;
         end
         if (isWreg && !busy
            && link.reqAddr == dst_pkg::REG_SELF_TEST_CONTROL) begin
            selfTestCtrl_r <= link.reqData;
         end
         if (isWreg && !busy
            && link.reqAddr == dst_pkg::REG_TEST_SELECT_TWO) begin
            testSelTwo_r <= link.reqData;
         end
         if (startTest && !busy) begin
            running_r <= 1'b1;
            sigIdx_r <= 7'h00;
            done_r <= 1'b0;
         end else if (running_r) begin
            sigIdx_r <= sigIdx_r + 7'h01;
            if (sigIdx_r == 7'(dst_pkg::SIGNATURE_BYTES - 1)) begin
               running_r <= 1'b0;
               done_r <= 1'b1;
            end
         end
      end
   end

   // FIFO: buffer store empties it; the test refills 64 signature bytes.
   always_ff @(posedge sys_clk) begin
      if (srst || (cmdReset && !busy) || (cmdStore && !busy)
         || (startTest && !busy)) begin
         fifoCnt_r <= 7'h00;
         rdPtr_r <= 6'h00;
         wrPtr_r <= 6'h00;
      end else if (running_r) begin
         fifoMem[wrPtr_r] <= sigByte;
         wrPtr_r <= wrPtr_r + 6'h01;
         fifoCnt_r <= fifoCnt_r + 7'h01;
      end else begin
         if (fifoWr && !busy) begin
            fifoMem[wrPtr_r] <= link.reqData;
            wrPtr_r <= wrPtr_r + 6'h01;
         end
         if (fifoRd && !busy) begin
            rdPtr_r <= rdPtr_r + 6'h01;
         end
         fifoCnt_r <= 7'(fifoCnt_r + 7'(fifoWr && !busy)
            - 7'(fifoRd && !busy));
      end
   end

   // Read answer: one-cycle pulse, zero when FIFO is empty.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rspValid_r <= 1'b0;
         rspData_r <= 8'h00;
      end else begin
         rspValid_r <= isRead && !busy;
         rspData_r <= fifoRd ? fifoMem[rdPtr_r] : 8'h00;
      end
   end

   // ****************************************************************
   // Test bus
   // ****************************************************************
   // Two-flop synchronisers on the asynchronous internal signals.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         syncA_r <= 2'h0;
         syncB_r <= 2'h0;
         syncC_r <= 7'h00;
         syncD_r <= 7'h00;
         oscDiv_r <= 3'h0;
      end else begin
         syncA_r <= {rxData, rxCollision};
         syncB_r <= syncA_r;
         syncC_r <= {rxValid, rxStop, receiver_reset_flag, clkStable,
            oscClk, 2'h0};
         syncD_r <= syncC_r;
         oscDiv_r <= oscDiv_r + 3'(syncD_r[2] && !oscClkPrev_r);
      end
   end

   // Edge memory for the divide-by-eight counter.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         oscClkPrev_r <= 1'b0;
      end else begin
         oscClkPrev_r <= syncD_r[2];
      end
   end

   wire [4:0] tbSel = testSelTwo_r[dst_pkg::TBS_MSB:0];
   wire [5:0] rxSet = {syncB_r[1], syncB_r[0], syncD_r[6], syncD_r[5],
      syncD_r[4], 1'b0};
   wire [5:0] clkSet = {syncD_r[3], oscDiv_r[2], 1'b0, 1'b0,
      syncD_r[2], 1'b0};
   wire [5:0] pinsNxt = tbSel == dst_pkg::TBS_RECEIVER ? rxSet :
      tbSel == dst_pkg::TBS_CLOCK ? clkSet : normalPins;

   // Registered pin drive.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pins_r <= 6'h00;
      end else begin
         pins_r <= pinsNxt;
      end
   end

   assign link.devBusy = busy;
   assign link.rspValid = rspValid_r;
   assign link.rspData = rspData_r;
   assign link.testPins = pins_r;
   assign selfTestDone = done_r;

endmodule

// ---- rtl/dst_host.sv ----
/*
 * Host end: APB slave registers and a sequencer that runs the
 * self-test procedure over the link.
 * Assumes the device answers reads one cycle after a request.
 */
`timescale 1ns/1ns
module dst_host (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to device.
   dst_link_if.host link
);

   typedef enum logic [2:0] {
      DST_S_IDLE = 3'h0, DST_S_RST = 3'h1, DST_S_WAIT = 3'h2,
      DST_S_FILL = 3'h3, DST_S_STORE = 3'h4, DST_S_EN = 3'h5,
      DST_S_ZERO = 3'h6, DST_S_CRC = 3'h7
   } dst_hstate_t;

   dst_hstate_t state_r;
   logic [4:0] cnt_r;
   logic done_r;
   logic [4:0] tbSel_r;
   logic [7:0] rdByte_r;
   logic reqValid_r;
   dst_pkg::dst_op_t reqOp_r;
   logic [5:0] reqAddr_r;
   logic [7:0] reqData_r;
   logic [31:0] prdata_r;
   logic pready_r;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // Writes land at the edge where pready is sampled high.
   wire apbAcc = psel && penable && pready_r;
   wire wrCtrl = apbAcc && pwrite && paddr == dst_pkg::APB_CTRL;
   wire wrTb = apbAcc && pwrite && paddr == dst_pkg::APB_TBSEL;
   wire goStart = wrCtrl && pwdata[dst_pkg::CTRL_START]
      && state_r == DST_S_IDLE;
   wire goTb = wrCtrl && pwdata[dst_pkg::CTRL_TBWR];
   wire goPop = wrCtrl && pwdata[dst_pkg::CTRL_POP];
   wire mapped = paddr == dst_pkg::APB_CTRL || paddr == dst_pkg::APB_STATUS
      || paddr == dst_pkg::APB_TBSEL || paddr == dst_pkg::APB_RDATA;
   wire [31:0] rdMux = paddr == dst_pkg::APB_STATUS ?
      {29'h0, link.devBusy, done_r, state_r != DST_S_IDLE} :
      paddr == dst_pkg::APB_TBSEL ? {27'h0, tbSel_r} :
      paddr == dst_pkg::APB_RDATA ? {18'h0, link.testPins, rdByte_r} :
      32'h0;

   // APB answers after one wait cycle in the access phase.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready_r <= psel && penable && !pready_r;
         prdata_r <= rdMux;
         pslverr <= psel && penable && !pready_r && !mapped;
      end
   end

   // ****************************************************************
   // Procedure sequencer
   // ****************************************************************
   wire canIssue = !link.devBusy && !reqValid_r;
   // Steps run one request each (FILL runs 25, WAIT none), waiting while the device is busy.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_r <= DST_S_IDLE;
         cnt_r <= 5'h00;
         done_r <= 1'b0;
         tbSel_r <= 5'h00;
         rdByte_r <= 8'h00;
         reqValid_r <= 1'b0;
         reqOp_r <= dst_pkg::DST_OP_NONE;
         reqAddr_r <= 6'h00;
         reqData_r <= 8'h00;
      end else begin
         reqValid_r <= 1'b0;
         if (wrTb) begin
            tbSel_r <= pwdata[4:0];
         end
         if (link.rspValid) begin
            rdByte_r <= link.rspData;
         end
         unique case (state_r)
            DST_S_IDLE: begin
               if (goStart) begin
                  done_r <= 1'b0;
                  state_r <= DST_S_RST;
               end else if (goTb && canIssue) begin
                  reqValid_r <= 1'b1;
                  reqOp_r <= dst_pkg::DST_OP_WREG;
                  reqAddr_r <= dst_pkg::REG_TEST_SELECT_TWO;
                  reqData_r <= {3'h0, tbSel_r};
               end else if (goPop && canIssue) begin
                  reqValid_r <= 1'b1;
                  reqOp_r <= dst_pkg::DST_OP_RDFF;
               end
            end
            DST_S_RST: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_CMD;
               reqData_r <= {4'h0, dst_pkg::CMD_SOFT_RESET};
               cnt_r <= 5'h00;
               state_r <= DST_S_WAIT;
            end
            DST_S_WAIT: if (canIssue) begin
               state_r <= DST_S_FILL;
            end
            DST_S_FILL: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_WREG;
               reqAddr_r <= dst_pkg::REG_FIFO_DATA;
               reqData_r <= dst_pkg::FILL_BYTE;
               cnt_r <= cnt_r + 5'h01;
               if (cnt_r == 5'(dst_pkg::BUFFER_CLEAR_BYTES - 1)) begin
                  state_r <= DST_S_STORE;
               end
            end
            DST_S_STORE: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_CMD;
               reqData_r <= {4'h0, dst_pkg::CMD_BUFFER_STORE};
               state_r <= DST_S_EN;
            end
            DST_S_EN: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_WREG;
               reqAddr_r <= dst_pkg::REG_SELF_TEST_CONTROL;
               reqData_r <= dst_pkg::SELF_TEST_ENABLE;
               state_r <= DST_S_ZERO;
            end
            DST_S_ZERO: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_WREG;
               reqAddr_r <= dst_pkg::REG_FIFO_DATA;
               reqData_r <= dst_pkg::FILL_BYTE;
               state_r <= DST_S_CRC;
            end
            DST_S_CRC: if (canIssue) begin
               reqValid_r <= 1'b1;
               reqOp_r <= dst_pkg::DST_OP_CMD;
               reqData_r <= {4'h0, dst_pkg::CMD_CRC_CALCULATE};
               done_r <= 1'b1;
               state_r <= DST_S_IDLE;
            end
         endcase
      end
   end

   // Each request is a single framed transfer.
   assign link.reqValid = reqValid_r;
   assign link.reqOp = reqOp_r;
   assign link.reqAddr = reqAddr_r;
   assign link.reqData = reqData_r;
   assign prdata = prdata_r;
   assign pready = pready_r;

endmodule

// ---- sim/dst_props.sv ----
/* Assertions on the link between the two self-test ends.
 * Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module dst_props (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic srst,
   // Link signals.
   input wire logic reqValid,
   input wire dst_pkg::dst_op_t reqOp,
   input wire logic [5:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic devBusy,
   input wire logic rspValid,
   input wire logic [7:0] rspData,
   input wire logic [5:0] testPins
);
   // ***********
   // Helper state
   // ***********
   logic stOn_r;
   logic rdTaken_r;
   logic [4:0] sel_r;
   logic [2:0] selAge_r;
   // Requests the device accepts and what they carry.
   wire taken = reqValid && !devBusy;
   wire isCmd = taken && reqOp == dst_pkg::DST_OP_CMD;
   wire isWr = taken && reqOp == dst_pkg::DST_OP_WREG;
   wire crcCmd = reqData[3:0] == dst_pkg::CMD_CRC_CALCULATE;
   wire crcGo = isCmd && crcCmd && stOn_r;
   wire softGo = isCmd && reqData[3:0] == dst_pkg::CMD_SOFT_RESET;
   wire rdGo = taken && reqOp == dst_pkg::DST_OP_RDFF;
   wire selWr = isWr && reqAddr == dst_pkg::REG_TEST_SELECT_TWO;
   wire stWr = isWr && reqAddr == dst_pkg::REG_SELF_TEST_CONTROL;
   wire settled = selAge_r == 3'h7;
   wire storeGo = isCmd && reqData[3:0] == dst_pkg::CMD_BUFFER_STORE;
   wire fifoPut = isWr && reqAddr == dst_pkg::REG_FIFO_DATA;
   wire crcAny = isCmd && crcCmd;
   logic [5:0] fillCnt_r;

   // Counts FIFO bytes written since the last soft reset or store.
   always_ff @(posedge sys_clk) begin
      if (srst || softGo || storeGo) begin
         fillCnt_r <= 6'h00;
      end else if (fifoPut && fillCnt_r != 6'h3F) begin
         fillCnt_r <= fillCnt_r + 6'h01;
      end
   end

   // Tracks the enable and the select; a soft reset forgets both.
   always_ff @(posedge sys_clk) begin
      if (srst || softGo) begin
         stOn_r <= 1'b0;
         sel_r <= 5'h00;
         selAge_r <= 3'h0;
      end else if (selWr) begin
         sel_r <= reqData[4:0];
         selAge_r <= 3'h0;
      end else begin
         if (stWr) stOn_r <= reqData == dst_pkg::SELF_TEST_ENABLE;
         if (!settled) selAge_r <= selAge_r + 3'h1;
      end
   end

   // Marks the cycle after an accepted FIFO read.
   always_ff @(posedge sys_clk) begin
      rdTaken_r <= !srst && rdGo;
   end

   // ***********
   // Properties
   // ***********
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   sequence busyRun;
      devBusy [*8];
   endsequence
   sequence resetRun;
      busyRun ##[1:12] !devBusy;
   endsequence

   a_reset_quiet: assert property ($fell(srst) |->
      !devBusy && !rspValid && testPins == 6'h00)
      else $error("link outputs not quiet after reset");
   a_sreset_busy: assert property (softGo |=> resetRun)
      else $error("soft reset busy window wrong");
   a_crc_busy: assert property (crcGo |=> busyRun)
      else $error("self-test did not start");
   a_crc_done: assert property (crcGo |-> ##[63:66] !devBusy)
      else $error("self-test did not finish in time");
   a_read_answer: assert property (rdGo |=> rspValid ##1 !rspValid)
      else $error("read answer not a single pulse");
   a_rsp_cause: assert property (rspValid |-> rdTaken_r)
      else $error("read answer without a read");
   a_rsv_recv: assert property (settled &&
      sel_r == dst_pkg::TBS_RECEIVER |-> !testPins[0])
      else $error("reserved pin driven in receiver set");
   a_rsv_clock: assert property (settled &&
      sel_r == dst_pkg::TBS_CLOCK |-> testPins[3:2] == 2'b00 && !testPins[0])
      else $error("reserved pin driven in clock set");
   a_fill_before_store: assert property (storeGo |->
      fillCnt_r == 6'(dst_pkg::BUFFER_CLEAR_BYTES))
      else $error("buffer store without the full zero fill");
   a_zero_before_crc: assert property (crcAny |->
      fillCnt_r == 6'h01)
      else $error("self-test start without one zero byte");
   a_crc_enabled: assert property (crcAny |-> stOn_r)
      else $error("calculate command before self-test enable");
   a_req_single: assert property (reqValid |=> !reqValid)
      else $error("request held longer than one cycle");
endmodule

// ---- sim/dst_tb_top.sv ----
/* Bench for the self-test link: APB host end and device end together.
 * Assumes a 100 MHz clock and the link interface between the ends. */
`timescale 1ns/1ns
module dst_tb_top;
   // ***********
   // Signals and instances
   // ***********
   localparam logic [7:0] CTRL = dst_pkg::APB_CTRL;
   localparam logic [7:0] STAT = dst_pkg::APB_STATUS;
   localparam logic [7:0] TBSEL = dst_pkg::APB_TBSEL;
   localparam logic [7:0] RDAT = dst_pkg::APB_RDATA;
   localparam int LIMIT = 20000;
   // Test-bus table: select, inputs, expected pins and pin mask.
   localparam logic [4:0] CODE [6] = '{5'h07, 5'h07, 5'h0D, 5'h0D,
      5'h1F, 5'h00};
   localparam logic [6:0] PAT [6] = '{7'h54, 7'h28, 7'h03, 7'h7C,
      7'h7F, 7'h00};
   localparam logic [5:0] EXP [6] = '{6'h2A, 6'h14, 6'h22, 6'h00,
      6'h15, 6'h15};
   localparam logic [5:0] MSK [6] = '{6'h3F, 6'h3F, 6'h2F, 6'h2F,
      6'h3F, 6'h3F};
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic selfTestDone;
   logic rxData = 1'b0;
   logic rxCollision = 1'b0;
   logic rxValid = 1'b0;
   logic rxStop = 1'b0;
   logic rcvRstFlag = 1'b0;
   logic clkStable = 1'b0;
   logic oscClk = 1'b0;
   logic [5:0] normalPins = 6'h15;
   logic [31:0] rd;
   logic err;
   int nFail = 0;
   int checkCount = 0;
   int cycles = 0;

   dst_link_if dst_link_if_i ();
   dst_host dst_host_i (.sys_clk(sys_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(dst_link_if_i));
   dst_device dst_device_i (.sys_clk(sys_clk), .srst(srst),
      .link(dst_link_if_i), .rxData(rxData), .rxCollision(rxCollision),
      .rxValid(rxValid), .rxStop(rxStop),
      .receiver_reset_flag(rcvRstFlag), .clkStable(clkStable),
      .oscClk(oscClk), .normalPins(normalPins),
      .selfTestDone(selfTestDone));
   dst_props dst_props_i (.sys_clk(sys_clk), .srst(srst),
      .reqValid(dst_link_if_i.reqValid), .reqOp(dst_link_if_i.reqOp),
      .reqAddr(dst_link_if_i.reqAddr), .reqData(dst_link_if_i.reqData),
      .devBusy(dst_link_if_i.devBusy), .rspValid(dst_link_if_i.rspValid),
      .rspData(dst_link_if_i.rspData),
      .testPins(dst_link_if_i.testPins));

   // The clock toggles every half period of 5 ns.
   always #5 sys_clk = ~sys_clk;

   // ***********
   // Tasks
   // ***********
   // Prints the counts and the verdict, then stops.
   task giveVerdict;
      begin
         $display("checks %0d, mismatches %0d", checkCount, nFail);
         if (nFail == 0 && checkCount > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask

   // Compares one value and counts the outcome.
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      begin
         checkCount++;
         if (g !== e) begin
            nFail++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
         end
      end
   endtask

   // One APB transfer; read data and error land in rd and err.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         do begin
            @(posedge sys_clk);
            n++;
         end while (pready !== 1'b1 && n < 50);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         chk("pready seen", 32'h1, {31'h0, pready});
      end
   endtask

   // Polls one status bit until it reaches v, within lim reads after the first.
   task waitStat(input int b, input logic v, input int lim);
      int n;
      begin
         n = 0;
         apb(1'b0, STAT, 32'h0);
         while (rd[b] !== v && n < lim) begin
            apb(1'b0, STAT, 32'h0);
            n++;
         end
         chk("status bit", {31'h0, v}, {31'h0, rd[b]});
      end
   endtask

   // Reads the pins through the host until they settle, then compares.
   task pins(input logic [5:0] e, input logic [5:0] m);
      int n;
      begin
         n = 0;
         apb(1'b0, RDAT, 32'h0);
         while ((rd[13:8] & m) !== e && n < 10) begin
            apb(1'b0, RDAT, 32'h0);
            n++;
         end
         chk("test pins", {26'h0, e}, {26'h0, rd[13:8] & m});
      end
   endtask

   // ***********
   // Tests
   // ***********
   // Cuts a hang short and reports it as a mismatch.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         nFail++;
         giveVerdict();
      end
   end

   // Reset, then self-test with signature readout, then the test bus.
   initial begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      apb(1'b0, STAT, 32'h0);
      chk("status after reset", 32'h0, rd);
      chk("status error", 32'h0, {31'h0, err});
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, CTRL, 32'h1);
      waitStat(1, 1'b1, 400);
      waitStat(2, 1'b0, 400);
      chk("test done", 32'h1, {31'h0, selfTestDone});
      for (int i = 0; i < 64; i++) begin
         apb(1'b1, CTRL, 32'h4);
         waitStat(2, 1'b0, 20);
         apb(1'b0, RDAT, 32'h0);
         chk("fifo byte", {24'h0, dst_pkg::SIGNATURE[511-8*i -: 8]},
            {24'h0, rd[7:0]});
      end
      $display("test self-test done");
      for (int k = 0; k < 6; k++) begin
         @(posedge sys_clk);
         {rxData, rxCollision, rxValid, rxStop, rcvRstFlag, clkStable,
            oscClk} <= PAT[k];
         apb(1'b1, TBSEL, {27'h0, CODE[k]});
         apb(1'b1, CTRL, 32'h2);
         pins(EXP[k], MSK[k]);
      end
      // The loop above gave two oscillator rises; four make D5 high.
      apb(1'b1, TBSEL, {27'h0, dst_pkg::TBS_CLOCK});
      apb(1'b1, CTRL, 32'h2);
      for (int j = 0; j < 6; j++) begin
         oscClk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         oscClk <= 1'b0;
         repeat (4) @(posedge sys_clk);
         if (j == 1) pins(6'h10, 6'h10);
      end
      pins(6'h00, 6'h10);
      $display("test test-bus done");
      giveVerdict();
   end
endmodule
